// ---- core/bpg_pkg.sv ----
// package of constants for the bus-pin output latch with set/clear aliases
package bpg_pkg;
  localparam logic [11:0] PIN_FUNCTION_SELECT_OFF = 12'h048;
  localparam logic [11:0] PIN_DIRECTION_CONTROL_OFF = 12'h04c;
  localparam logic [11:0] PIN_INPUT_OFF = 12'h050;
  localparam logic [11:0] PIN_OUTPUT_LATCH_OFF = 12'h054;
  localparam logic [11:0] PIN_OUTPUT_SET_ALIAS_OFF = 12'h058;
  localparam logic [11:0] PIN_OUTPUT_CLEAR_ALIAS_OFF = 12'h05c;
  localparam int DATA_LINE_BIT = 1;
  localparam int CLOCK_LINE_BIT = 0;
  localparam int GENERAL_PIN_MODE_BIT = 0;
  localparam logic [1:0] LATCH_RESET = 2'h0;
  localparam logic [1:0] DIRECTION_RESET = 2'h0;
  localparam logic FUNCTION_RESET = 1'b0;
  localparam logic [31:0] ALIAS_READ_VALUE = 32'h0000_0000;
  localparam logic [31:0] READ_DATA_RESET = 32'h0000_0000;
  localparam logic ANSWER_FLAG_RESET = 1'b0;
  localparam logic PIN_DRIVE_RESET = 1'b0;
  localparam logic SYNC_RESET = 1'b0;
endpackage

// ---- core/bpg_sync2.sv ----
// two-flop synchroniser for one pin input
`timescale 1ns/1ns
module bpg_sync2 (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic async_in,
  output logic sync_out
);
  logic meta_reg;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_reg <= bpg_pkg::SYNC_RESET;
      sync_out <= bpg_pkg::SYNC_RESET;
    end else begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
    end
  end
endmodule

// ---- core/bpg_top.sv ----
// apb slave: pin function, direction, input, output latch and its aliases
`timescale 1ns/1ns
module bpg_top (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic data_line_in,
  input wire logic clock_line_in,
  output logic data_line_out,
  output logic data_line_oe,
  output logic clock_line_out,
  output logic clock_line_oe,
  output logic general_pin_mode_enable
);
  // ****************************************
  // state
  // ****************************************
  logic [1:0] pin_output_latch_reg;
  logic [1:0] pin_output_latch_next;
  logic [1:0] pin_direction_control_reg;
  logic [1:0] pin_direction_control_next;
  logic pin_function_select_reg;
  logic pin_function_select_next;
  logic [1:0] pin_in_sync;
  logic [31:0] prdata_next;
  logic pready_next;
  logic pslverr_next;
  logic [1:0] pin_out_next;
  logic [1:0] pin_oe_next;

  // ****************************************
  // pin input synchronisers
  // ****************************************
  bpg_sync2 u_sync_data (
    .pclk(pclk),
    .presetn(presetn),
    .async_in(data_line_in),
    .sync_out(pin_in_sync[bpg_pkg::DATA_LINE_BIT])
  );
  bpg_sync2 u_sync_clock (
    .pclk(pclk),
    .presetn(presetn),
    .async_in(clock_line_in),
    .sync_out(pin_in_sync[bpg_pkg::CLOCK_LINE_BIT])
  );

  // ****************************************
  // bus phase decode
  // ****************************************
  wire setup_phase = psel & ~penable;
  wire access_phase = psel & penable;
  // writes land only at the edge that completes the transfer
  wire access_done = access_phase & pready;
  wire wr_en = access_done & pwrite & pstrb[0];
  wire rd_en = setup_phase & ~pwrite;

  // ****************************************
  // address decode
  // ****************************************
  wire hit_func = paddr == bpg_pkg::PIN_FUNCTION_SELECT_OFF;
  wire hit_dir = paddr == bpg_pkg::PIN_DIRECTION_CONTROL_OFF;
  wire hit_in = paddr == bpg_pkg::PIN_INPUT_OFF;
  wire hit_latch = paddr == bpg_pkg::PIN_OUTPUT_LATCH_OFF;
  wire hit_set = paddr == bpg_pkg::PIN_OUTPUT_SET_ALIAS_OFF;
  wire hit_clr = paddr == bpg_pkg::PIN_OUTPUT_CLEAR_ALIAS_OFF;
  wire hit_any = hit_func | hit_dir | hit_in | hit_latch | hit_set | hit_clr;

  // ****************************************
  // write enables and data
  // ****************************************
  wire wr_func = wr_en & hit_func;
  wire wr_dir = wr_en & hit_dir;
  wire wr_latch = wr_en & hit_latch;
  wire wr_set = wr_en & hit_set;
  wire wr_clr = wr_en & hit_clr;
  // reserved bits 31:2 never reach a register
  wire [1:0] wr_bits = pwdata[1:0];
  wire wr_mode_bit = pwdata[bpg_pkg::GENERAL_PIN_MODE_BIT];
  wire [1:0] set_mask = wr_set ? wr_bits : 2'h0;
  wire [1:0] clr_mask = wr_clr ? wr_bits : 2'h0;

  // ****************************************
  // next register values
  // ****************************************
  // direct write first, then the aliases; one write hits one address,
  // so set and clear never meet in the same cycle
  always_comb begin
    pin_output_latch_next = pin_output_latch_reg;
    if (wr_latch) begin
      pin_output_latch_next = wr_bits;
    end
    pin_output_latch_next = pin_output_latch_next | set_mask;
    pin_output_latch_next = pin_output_latch_next & ~clr_mask;
  end

  always_comb begin
    pin_direction_control_next = pin_direction_control_reg;
    if (wr_dir) begin
      pin_direction_control_next = wr_bits;
    end
  end

  always_comb begin
    pin_function_select_next = pin_function_select_reg;
    if (wr_func) begin
      pin_function_select_next = wr_mode_bit;
    end
  end

  // ****************************************
  // read data and bus answer
  // ****************************************
  wire [31:0] func_word = {31'h0, pin_function_select_reg};
  wire [31:0] dir_word = {30'h0, pin_direction_control_reg};
  wire [31:0] in_word = {30'h0, pin_in_sync};
  wire [31:0] latch_word = {30'h0, pin_output_latch_reg};
  // aliases and unmapped offsets read as zero
  wire [31:0] rd_mux =
    hit_func ? func_word :
    hit_dir ? dir_word :
    hit_in ? in_word :
    hit_latch ? latch_word :
    bpg_pkg::ALIAS_READ_VALUE;

  // answer one cycle after setup: no wait states
  always_comb begin
    pready_next = setup_phase;
    pslverr_next = setup_phase & ~hit_any;
    prdata_next = bpg_pkg::READ_DATA_RESET;
    if (rd_en) begin
      prdata_next = rd_mux;
    end
  end

  // ****************************************
  // pin drive
  // ****************************************
  // the level always follows the latch; only the enable is qualified,
  // so a pin that is not a general output is never driven
  wire [1:0] mode_mask = {2{pin_function_select_reg}};
  always_comb begin
    pin_out_next = pin_output_latch_reg;
    pin_oe_next = pin_direction_control_reg & mode_mask;
  end

  // ****************************************
  // registers
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_output_latch_reg <= bpg_pkg::LATCH_RESET;
    end else begin
      pin_output_latch_reg <= pin_output_latch_next;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_direction_control_reg <= bpg_pkg::DIRECTION_RESET;
    end else begin
      pin_direction_control_reg <= pin_direction_control_next;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_function_select_reg <= bpg_pkg::FUNCTION_RESET;
    end else begin
      pin_function_select_reg <= pin_function_select_next;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= bpg_pkg::READ_DATA_RESET;
    end else begin
      prdata <= prdata_next;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= bpg_pkg::ANSWER_FLAG_RESET;
    end else begin
      pready <= pready_next;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pslverr <= bpg_pkg::ANSWER_FLAG_RESET;
    end else begin
      pslverr <= pslverr_next;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      data_line_out <= bpg_pkg::PIN_DRIVE_RESET;
    end else begin
      data_line_out <= pin_out_next[bpg_pkg::DATA_LINE_BIT];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clock_line_out <= bpg_pkg::PIN_DRIVE_RESET;
    end else begin
      clock_line_out <= pin_out_next[bpg_pkg::CLOCK_LINE_BIT];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      data_line_oe <= bpg_pkg::PIN_DRIVE_RESET;
    end else begin
      data_line_oe <= pin_oe_next[bpg_pkg::DATA_LINE_BIT];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clock_line_oe <= bpg_pkg::PIN_DRIVE_RESET;
    end else begin
      clock_line_oe <= pin_oe_next[bpg_pkg::CLOCK_LINE_BIT];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      general_pin_mode_enable <= bpg_pkg::PIN_DRIVE_RESET;
    end else begin
      general_pin_mode_enable <= pin_function_select_reg;
    end
  end
endmodule

// ---- verification/bpg_top_assertions.sv ----
// assertions on the output latch, its aliases and the pin enables
`timescale 1ns/1ns
module bpg_top_assertions (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic data_line_out,
  input wire logic clock_line_out,
  input wire logic data_line_oe,
  input wire logic clock_line_oe,
  input wire logic general_pin_mode_enable
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_wr(logic [11:0] a);
    psel && penable && pready && pwrite && pstrb[0] && paddr == a;
  endsequence
  sequence s_rd(logic [11:0] a);
    psel && penable && pready && !pwrite && paddr == a;
  endsequence
  a_set_data: assert property (s_wr(12'h058) ##0 pwdata[1]
    |-> ##2 data_line_out) else $error("set data");
  a_set_clock: assert property (s_wr(12'h058) ##0 pwdata[0]
    |-> ##2 clock_line_out) else $error("set clock");
  a_clr_data: assert property (s_wr(12'h05c) ##0 pwdata[1]
    |-> ##2 !data_line_out) else $error("clear data");
  a_clr_clock: assert property (s_wr(12'h05c) ##0 pwdata[0]
    |-> ##2 !clock_line_out) else $error("clear clock");
  a_zero_keeps: assert property ((s_wr(12'h058) or s_wr(12'h05c))
    ##0 pwdata[1:0] == 2'h0 |-> ##2 $stable({data_line_out, clock_line_out}))
    else $error("zero write");
  a_alias_zero: assert property ((s_rd(12'h058) or s_rd(12'h05c))
    |-> prdata == 32'h0000_0000) else $error("alias read");
  a_latch_read: assert property (s_rd(12'h054)
    |-> prdata == {30'h0, data_line_out, clock_line_out})
    else $error("latch read");
  a_oe_mode: assert property (data_line_oe
    |-> general_pin_mode_enable) else $error("oe mode");
  a_clock_oe_mode: assert property (clock_line_oe
    |-> general_pin_mode_enable) else $error("clock oe mode");
  a_ready_next: assert property (psel && !penable
    |=> pready) else $error("ready late");
endmodule

// ---- verification/tb_bpg_top.sv ----
// bench for the set and clear aliases of the pin output latch
`timescale 1ns/1ns
module tb_bpg_top;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
  logic pwrite = 1'b0, data_line_in = 1'b1, clock_line_in = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
  logic [3:0] pstrb = 4'hf;
  logic [3:0] pins;
  logic pready, pslverr, err, data_line_out, data_line_oe;
  logic clock_line_out, clock_line_oe, general_pin_mode_enable;
  int n_errors = 0, samples_checked = 0;
  logic [11:0] ta [7] = '{12'h058, 12'h058, 12'h05c, 12'h058, 12'h05c,
    12'h054, 12'h05c};
  logic [31:0] td [7] = '{32'h0000_0002, 32'h0000_0001, 32'h0000_0002,
    32'hffff_fffc, 32'h0000_0001, 32'h0000_0003, 32'h0000_0000};
  logic [31:0] te [7] = '{32'h0000_0002, 32'h0000_0003, 32'h0000_0001,
    32'h0000_0001, 32'h0000_0000, 32'h0000_0003, 32'h0000_0003};
  bpg_top u_bpg_top (
    .pclk(pclk),
    .presetn(presetn),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .pstrb(pstrb),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .data_line_in(data_line_in),
    .clock_line_in(clock_line_in),
    .data_line_out(data_line_out),
    .data_line_oe(data_line_oe),
    .clock_line_out(clock_line_out),
    .clock_line_oe(clock_line_oe),
    .general_pin_mode_enable(general_pin_mode_enable)
  );
  always #4 pclk = ~pclk;
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic end_sim;
    $display("errors=%0d checks=%0d", n_errors, samples_checked);
    if (n_errors == 0 && samples_checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [11:0] a,
      input logic [31:0] d);
    int i;
    i = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && i < 8) begin
      @(posedge pclk);
      i++;
    end
    if (pready !== 1'b1) begin
      chk(pready, 1'b1);
      end_sim();
    end else begin
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask
  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, 12'h054, 32'h0000_0000);
    chk(rd, 32'h0000_0000);
    for (int k = 0; k < 7; k++) begin
      apb(1'b1, ta[k], td[k]);
      chk(err, 1'b0);
      apb(1'b0, 12'h054, 32'h0000_0000);
      chk(rd, te[k]);
      chk({data_line_out, clock_line_out}, te[k]);
    end
    apb(1'b1, 12'h05d, 32'h0000_0003);
    chk(err, 1'b1);
    apb(1'b0, 12'h054, 32'h0000_0000);
    chk(rd, 32'h0000_0003);
    chk({data_line_oe, clock_line_oe}, 2'h0);
    apb(1'b0, 12'h058, 32'h0000_0000);
    chk(rd, 32'h0000_0000);
    chk(rd[31:2], 30'h0);
    apb(1'b0, 12'h05c, 32'h0000_0000);
    chk(rd, 32'h0000_0000);
    apb(1'b1, 12'h048, 32'h0000_0001);
    apb(1'b1, 12'h04c, 32'h0000_0003);
    apb(1'b0, 12'h054, 32'h0000_0000);
    chk(general_pin_mode_enable, 1'b1);
    pins = {data_line_out, data_line_oe, clock_line_out, clock_line_oe};
    chk(pins, 4'hf);
    apb(1'b1, 12'h05c, 32'h0000_0002);
    apb(1'b0, 12'h054, 32'h0000_0000);
    pins = {data_line_out, data_line_oe, clock_line_out, clock_line_oe};
    chk(pins, 4'h7);
    apb(1'b1, 12'h04c, 32'h0000_0001);
    apb(1'b0, 12'h054, 32'h0000_0000);
    pins = {data_line_out, data_line_oe, clock_line_out, clock_line_oe};
    chk(pins, 4'h3);
    end_sim();
  end
endmodule
bind bpg_top bpg_top_assertions u_bpg_top_assertions (
  .pclk(pclk),
  .presetn(presetn),
  .psel(psel),
  .penable(penable),
  .pwrite(pwrite),
  .paddr(paddr),
  .pwdata(pwdata),
  .pstrb(pstrb),
  .prdata(prdata),
  .pready(pready),
  .data_line_out(data_line_out),
  .clock_line_out(clock_line_out),
  .data_line_oe(data_line_oe),
  .clock_line_oe(clock_line_oe),
  .general_pin_mode_enable(general_pin_mode_enable)
);
